// ---- shared/pal_consts.svh ----
// constants of the converter output logic: widths, stage layout, latency counts
// assumes inclusion by its bare name from the package and the design files
`ifndef PAL_CONSTS_SVH
`define PAL_CONSTS_SVH

`define PAL_WORD_W        10
`define PAL_MSB           9
`define PAL_LSB           0
`define PAL_STAGES        10
`define PAL_TWO_BIT_STGS  9
`define PAL_CODE_W        2
`define PAL_STAGE_BITS    19
`define PAL_SUM_W         12
`define PAL_WORD_MAX      12'h3FF
`define PAL_ALIGN_HALVES  10
`define PAL_LATENCY       7
`define PAL_INVALID_TICKS 20
`define PAL_TICK_CNT_W    3
`define PAL_BUF_DEPTH     2
`define PAL_FMT_OFFSET    1'b0

`endif

// ---- shared/pal_pkg.sv ----
// types shared by the converter output logic
// assumes pal_consts.svh on the include path
`include "pal_consts.svh"

package pal_pkg;

  typedef logic [`PAL_WORD_W-1:0]     pal_word_t;
  typedef logic [`PAL_CODE_W-1:0]     pal_code_t;
  typedef logic [`PAL_STAGE_BITS-1:0] pal_stage_bits_t;

  typedef enum logic {
    PAL_WARM,
    PAL_RUN
  } pal_state_t;

endpackage : pal_pkg

// ---- design/pal_dly.sv ----
// one stage's capture flop and its alignment delay line
// assumes one clock; cap_en marks the stage's own phase edge, sh_en every half period
`include "pal_consts.svh"

module pal_dly #(
  parameter int DEPTH = 1
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  input  wire logic              cap_en,
  input  wire logic              sh_en,
  input  wire pal_pkg::pal_code_t din,
  output pal_pkg::pal_code_t     dout
);

  pal_pkg::pal_code_t r [DEPTH];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r[0] <= '0;
    end else if (cap_en) begin
      r[0] <= din;
    end
  end

  // every later tap moves on each half period so all stages land together
  for (genvar k = 1; k < DEPTH; k++) begin : g_tap
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        r[k] <= '0;
      end else if (sh_en) begin
        r[k] <= r[k-1];
      end
    end
  end

  assign dout = r[DEPTH-1];

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  stage_phase_a: assert property ($changed(r[0]) |-> $past(cap_en))
    else $error("stage result moved off its own phase");

endmodule : pal_dly

// ---- design/pal_buf.sv ----
// two-entry word buffer with valid and ready on both sides
// assumes one clock; the drain side may stall, the fill side sees in_ready
`include "pal_consts.svh"

module pal_buf #(
  parameter int W     = `PAL_WORD_W,
  parameter int DEPTH = `PAL_BUF_DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_r != FULL);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rd_r];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_r] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == LAST) ? '0 : wr_r + AW'(1);
      end
      if (pop) begin
        rd_r <= (rd_r == LAST) ? '0 : rd_r + AW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= '0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_r <= cnt_r - (AW+1)'(1);
    end
  end

endmodule : pal_buf

// ---- design/pal_top.sv ----
// digital side of a 10-bit pipelined converter: phases, alignment, correction, output bus
// assumes sample_clk and the control pins are synchronous to ref_clk and much slower than it;
// stage_bits carries each stage's flash decision, valid at that stage's phase edge
`include "pal_consts.svh"

module pal_top (
  input  wire logic                    ref_clk,
  input  wire logic                    nrst,
  input  wire logic                    sample_clk,
  input  wire pal_pkg::pal_stage_bits_t stage_bits,
  input  wire logic                    format_select,
  input  wire logic                    output_drive_enable_n,
  output pal_pkg::pal_word_t           result_data,
  output logic                         result_oe,
  output logic                         result_msb,
  output logic                         result_lsb,
  output logic                         word_valid,
  output logic                         sample_phase,
  output logic                         hold_phase
);

  logic                  clk_d_r;
  logic                  rise_tick;
  logic                  fall_tick;
  logic                  half_tick;
  logic                  sample_phase_r;
  logic                  hold_phase_r;
  pal_pkg::pal_code_t    aligned [`PAL_STAGES];
  pal_pkg::pal_word_t    corr_word;
  logic                  buf_in_ready;
  logic                  buf_out_valid;
  pal_pkg::pal_word_t    buf_out_data;
  logic                  push;
  logic                  pop;
  pal_pkg::pal_word_t    result_data_r;
  logic                  word_valid_r;
  logic [`PAL_TICK_CNT_W-1:0] tick_cnt_r;
  pal_pkg::pal_state_t   state_r;
  pal_pkg::pal_state_t   state_nxt;

  // sample clock edges; the pin is taken as already synchronous
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      clk_d_r <= 1'b0;
    end else begin
      clk_d_r <= sample_clk;
    end
  end

  assign rise_tick = sample_clk && !clk_d_r;
  assign fall_tick = !sample_clk && clk_d_r;
  assign half_tick = rise_tick || fall_tick;

  // a phase is dropped during the edge cycle, which keeps the two apart
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sample_phase_r <= 1'b0;
      hold_phase_r   <= 1'b0;
    end else begin
      sample_phase_r <= !sample_clk && !clk_d_r;
      hold_phase_r   <= sample_clk && clk_d_r;
    end
  end

  assign sample_phase = sample_phase_r;
  assign hold_phase   = hold_phase_r;

  // stage i decides on half period i+1; even stages on falls, odd on rises,
  // then waits 9-i half periods so every result lands on the fifth rise
  for (genvar i = 0; i < `PAL_STAGES; i++) begin : g_stage
    pal_pkg::pal_code_t din;
    if (i < `PAL_TWO_BIT_STGS) begin : g_two
      assign din = stage_bits[2*i +: `PAL_CODE_W];
    end else begin : g_one
      assign din = {1'b0, stage_bits[`PAL_STAGE_BITS-1]};
    end
    pal_dly #(
      .DEPTH(`PAL_ALIGN_HALVES - i)
    ) u_dly (
      .ref_clk (ref_clk),
      .nrst    (nrst),
      .cap_en  ((i % 2 == 0) ? fall_tick : rise_tick),
      .sh_en   (half_tick),
      .din     (din),
      .dout    (aligned[i])
    );
  end

  // overlapping stage weights absorb flash errors; the top end is clamped
  function automatic pal_pkg::pal_word_t correct(input pal_pkg::pal_code_t c [`PAL_STAGES]);
    logic [`PAL_SUM_W-1:0] sum;
    sum = '0;
    for (int s = 0; s < `PAL_TWO_BIT_STGS; s++) begin
      sum = sum + (`PAL_SUM_W'(c[s]) << (`PAL_TWO_BIT_STGS - 1 - s));
    end
    sum = sum + `PAL_SUM_W'(c[`PAL_STAGES-1][0]);
    if (sum > `PAL_WORD_MAX) begin
      sum = `PAL_WORD_MAX;
    end
    return sum[`PAL_WORD_W-1:0];
  endfunction : correct

  assign corr_word = correct(aligned);

  // first latch is the buffer entry, second is the bus register
  assign push = rise_tick;
  assign pop  = rise_tick && buf_out_valid;

  pal_buf #(
    .W     (`PAL_WORD_W),
    .DEPTH (`PAL_BUF_DEPTH)
  ) u_buf (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (corr_word),
    .out_valid (buf_out_valid),
    .out_ready (rise_tick),
    .out_data  (buf_out_data)
  );

  // format is applied at the bus latch so a change takes effect on the next word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      result_data_r <= '0;
    end else if (pop) begin
      result_data_r <= buf_out_data;
      if (format_select != `PAL_FMT_OFFSET) begin
        result_data_r[`PAL_MSB] <= !buf_out_data[`PAL_MSB];
      end
    end
  end

  // warm-up: words before the pipe has filled carry no sample
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      pal_pkg::PAL_WARM: begin
        if (rise_tick && tick_cnt_r == `PAL_TICK_CNT_W'(`PAL_LATENCY - 1)) begin
          state_nxt = pal_pkg::PAL_RUN;
        end
      end
      pal_pkg::PAL_RUN: begin
        state_nxt = pal_pkg::PAL_RUN;
      end
      default: begin
        state_nxt = pal_pkg::PAL_WARM;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= pal_pkg::PAL_WARM;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= '0;
    end else if (rise_tick && state_r == pal_pkg::PAL_WARM) begin
      tick_cnt_r <= tick_cnt_r + `PAL_TICK_CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      word_valid_r <= 1'b0;
    end else if (rise_tick) begin
      word_valid_r <= (state_nxt == pal_pkg::PAL_RUN);
    end
  end

  assign word_valid  = word_valid_r;
  assign result_data = result_data_r;
  assign result_msb  = result_data_r[`PAL_MSB];
  assign result_lsb  = result_data_r[`PAL_LSB];
  // one enable for the whole bus; the pad ring resolves the float
  assign result_oe   = !output_drive_enable_n;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence s_rise_pop;
    rise_tick && buf_out_valid;
  endsequence

  sequence s_word_on_bus;
    ##1 result_data_r[`PAL_MSB-1:0] == $past(buf_out_data[`PAL_MSB-1:0]);
  endsequence

  first_word_a: assert property (
    rise_tick && state_r == pal_pkg::PAL_WARM
      && tick_cnt_r == `PAL_TICK_CNT_W'(`PAL_LATENCY - 1) |=> word_valid_r)
    else $error("first valid word not on the seventh clock");

  early_word_a: assert property (
    word_valid_r |-> tick_cnt_r == `PAL_TICK_CNT_W'(`PAL_LATENCY))
    else $error("word flagged valid before the latency elapsed");

  each_tick_a: assert property (
    s_rise_pop |-> s_word_on_bus)
    else $error("bus word not taken from buffer on the clock");

  latch_timing_a: assert property (
    $changed(result_data_r) |-> $past(rise_tick))
    else $error("bus word changed off the sample clock");

  format_msb_a: assert property (
    s_rise_pop |=> result_data_r[`PAL_MSB] ==
      ($past(buf_out_data[`PAL_MSB]) ^ $past(format_select)))
    else $error("top bit does not follow the format select");

  aligned_last_a: assert property (
    $changed(aligned[`PAL_STAGES-1]) |-> $past(rise_tick))
    else $error("last stage result moved off the rising edge");

  corr_range_a: assert property (
    aligned[0] == '0 |-> corr_word <= 10'h2FE)
    else $error("corrected word exceeds range of lower stages");

  phase_apart_a: assert property (
    !(sample_phase_r && hold_phase_r))
    else $error("sample and hold phases overlap");

  phase_order_a: assert property (
    $fell(sample_phase_r) && sample_clk |-> !hold_phase_r ##1 hold_phase_r || !sample_clk)
    else $error("hold phase does not follow the sample phase");

  drive_off_a: assert property (
    output_drive_enable_n |-> !result_oe)
    else $error("bus driven while output drive is disabled");

  buf_room_a: assert property (
    rise_tick |-> buf_in_ready)
    else $error("buffer full when a word arrives");

  valid_stays_a: assert property (
    word_valid_r |=> word_valid_r)
    else $error("valid flag dropped after the latency");

  warm_count_a: assert property (
    state_r == pal_pkg::PAL_WARM |-> tick_cnt_r < `PAL_TICK_CNT_W'(`PAL_LATENCY))
    else $error("warm-up ran past the latency count");

  run_valid_a: assert property (
    state_r == pal_pkg::PAL_RUN |-> word_valid_r)
    else $error("pipe filled but words not flagged valid");

  word_each_a: assert property (
    rise_tick && state_r == pal_pkg::PAL_RUN |-> buf_out_valid)
    else $error("no word ready on a sample clock after the latency");

  rise_gap_a: assert property (
    rise_tick |=> !sample_phase_r && !hold_phase_r)
    else $error("phases not parted at a sample clock rise");

  fall_gap_a: assert property (
    fall_tick |=> !sample_phase_r && !hold_phase_r)
    else $error("phases not parted at a sample clock fall");

  sample_low_a: assert property (
    sample_phase_r |-> !$past(sample_clk))
    else $error("sample phase high while the clock was high");

  hold_high_a: assert property (
    hold_phase_r |-> $past(sample_clk))
    else $error("hold phase high while the clock was low");

  drive_on_a: assert property (
    !output_drive_enable_n |-> result_oe)
    else $error("bus floated while output drive is enabled");

  lsb_format_a: assert property (
    s_rise_pop |=> result_data_r[`PAL_LSB] == $past(buf_out_data[`PAL_LSB]))
    else $error("format select touched a low bit");

  stage_last_a: assert property (
    rise_tick |=> aligned[`PAL_STAGES-1][1] == 1'b0)
    else $error("one-bit stage carries a second bit");

endmodule : pal_top

// ---- testbench/pal_cap_model.sv ----
// capture-side model: makes the sample clock and latches words from the output bus
// assumes ref_clk is the system clock; run starts the sample clock from its high half
module pal_cap_model (
  input  wire logic               ref_clk,
  input  wire logic               run,
  input  wire logic               result_oe,
  input  wire pal_pkg::pal_word_t result_data,
  output logic                    sample_clk,
  output pal_pkg::pal_word_t      word_q,
  output logic                    data_good
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] ph_r;
  logic [4:0] seen_r;
  logic       prev_r;

  initial begin
    sample_clk = 1'b0;
    ph_r = 3'h0;
    seen_r = 5'h00;
    prev_r = 1'b0;
    word_q = 10'h000;
  end

  // eight system cycles a sample keeps the rate far above the minimum
  always @(posedge ref_clk) begin
    ph_r <= run ? ph_r + 3'h1 : 3'h0;
    sample_clk <= run && (ph_r < 3'h4);
    prev_r <= sample_clk;
    if (!run) begin
      seen_r <= 5'h00;
    end else if (sample_clk && !prev_r) begin
      if (result_oe) begin
        word_q <= result_data;
      end
      if (seen_r != 5'h14) begin
        seen_r <= seen_r + 5'h01;
      end
    end
  end

  // words before twenty sample clocks are not trusted
  assign data_good = (seen_r == 5'h14);
endmodule : pal_cap_model

// ---- testbench/pal_top_tb.sv ----
// self-checking bench for pal_top: streams stage decisions, checks words, phases and bus enable
// assumes pal_cap_model makes the sample clock; stage decisions are driven from here
`include "pal_consts.svh"

module pal_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                     ref_clk;
  logic                     nrst;
  logic                     run;
  logic                     sample_clk;
  pal_pkg::pal_stage_bits_t stage_bits;
  logic                     format_select;
  logic                     output_drive_enable_n;
  pal_pkg::pal_word_t       result_data;
  logic                     result_oe;
  logic                     result_msb;
  logic                     result_lsb;
  logic                     word_valid;
  logic                     sample_phase;
  logic                     hold_phase;
  pal_pkg::pal_word_t       word_q;
  logic                     data_good;
  int                       err_total;
  int                       checked;
  logic [18:0]              samp [0:31];
  logic [18:0]              tbl [0:7] = '{19'h00000, 19'h7FFFF, 19'h40000, 19'h00001,
                                          19'h15555, 19'h2AAAA, 19'h6AAAA, 19'h40002};

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  pal_top dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .sample_clk(sample_clk), .stage_bits(stage_bits),
    .format_select(format_select), .output_drive_enable_n(output_drive_enable_n),
    .result_data(result_data), .result_oe(result_oe), .result_msb(result_msb),
    .result_lsb(result_lsb), .word_valid(word_valid), .sample_phase(sample_phase),
    .hold_phase(hold_phase)
  );

  pal_cap_model cap_u (
    .ref_clk(ref_clk), .run(run), .result_oe(result_oe), .result_data(result_data),
    .sample_clk(sample_clk), .word_q(word_q), .data_good(data_good)
  );

  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic chk1(input string nm, input logic seen, input logic exp);
    chk(nm, {9'h000, seen}, {9'h000, exp});
  endtask : chk1

  // weighted sum with one bit of overlap per stage, clamped at full scale
  function automatic pal_pkg::pal_word_t exp_word(input logic [18:0] v, input logic f);
    logic [11:0] s;
    s = {11'h000, v[18]};
    for (int i = 0; i < 9; i++) begin
      s = s + ({10'h000, v[2*i+:2]} << (8 - i));
    end
    if (s > 12'h3FF) begin
      s = 12'h3FF;
    end
    return s[9:0] ^ {f, 9'h000};
  endfunction : exp_word

  // stage j works on the sample taken j/2 periods earlier, so each field lags
  function automatic logic [18:0] comp(input int k);
    logic [18:0] c;
    c = 19'h00000;
    for (int i = 0; i < 19; i++) begin
      if (k - i / 4 >= 0) begin
        c[i] = samp[k - i / 4][i];
      end
    end
    return c;
  endfunction : comp

  task automatic wait_rise();
    logic p;
    @(posedge ref_clk);
    p = sample_clk;
    for (int i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (sample_clk && !p) begin
        return;
      end
      p = sample_clk;
    end
    err_total++;
    $display("MISMATCH sample clock rise expected 1 seen 0");
  endtask : wait_rise

  task automatic t_reset(input logic oen);
    @(posedge ref_clk);
    nrst <= 1'b0;
    run <= 1'b0;
    output_drive_enable_n <= oen;
    #1;
    chk("reset word", result_data, 10'h000);
    chk1("reset valid", word_valid, 1'b0);
    chk1("reset sample phase", sample_phase, 1'b0);
    chk1("reset hold phase", hold_phase, 1'b0);
    chk1("reset enable", result_oe, !oen);
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    run <= 1'b1;
    $display("test reset done");
  endtask : t_reset

  task automatic t_stream(input int sd, input logic [19:0] fmt_pat, input logic [19:0] oe_pat);
    logic               f;
    pal_pkg::pal_word_t w_exp;
    pal_pkg::pal_word_t cap_exp;
    for (int k = 0; k < 32; k++) begin
      samp[k] = tbl[(k * 3 + sd) % 8];
    end
    for (int p = 0; p < 20; p++) begin
      wait_rise();
      repeat (2) @(posedge ref_clk);
      f = format_select;
      stage_bits <= comp(p);
      format_select <= fmt_pat[p];
      output_drive_enable_n <= oe_pat[p];
      #1;
      // the capture side latched last period's word only while the bus was driven
      if (p > `PAL_LATENCY && !oe_pat[p-1]) begin
        cap_exp = w_exp;
      end
      if (p > `PAL_LATENCY) begin
        chk("captured word", word_q, cap_exp);
      end
      if (p >= `PAL_LATENCY) begin
        w_exp = exp_word(samp[p - `PAL_LATENCY], f);
        chk("word", result_data, w_exp);
        chk("word format", result_data ^ exp_word(samp[p - `PAL_LATENCY], 1'b0),
            {f, 9'h000});
        chk1("valid full", word_valid, 1'b1);
      end
      if (p == 5) begin
        chk1("valid early", word_valid, 1'b0);
      end
      chk1("msb", result_msb, result_data[9]);
      chk1("lsb", result_lsb, result_data[0]);
      chk1("enable", result_oe, !oe_pat[p]);
      chk1("capture ready", data_good, p == 19);
      @(posedge ref_clk);
      #1;
      chk1("hold high", hold_phase, 1'b1);
      chk1("sample low", sample_phase, 1'b0);
      repeat (3) @(posedge ref_clk);
      #1;
      chk1("sample high", sample_phase, 1'b1);
      chk1("hold low", hold_phase, 1'b0);
    end
    $display("test stream %0d done", sd);
  endtask : t_stream

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  initial begin
    nrst = 1'b0;
    run = 1'b0;
    stage_bits = 19'h00000;
    format_select = 1'b0;
    output_drive_enable_n = 1'b0;
    err_total = 0;
    checked = 0;
    t_reset(1'b1);
    t_stream(0, 20'hF0F0F, 20'h00C00);
    t_reset(1'b0);
    t_stream(5, 20'h33333, 20'h00000);
    close_out();
  end

  // whole run is near 400 cycles; ten times that means a hang
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_total++;
    close_out();
  end
endmodule : pal_top_tb
